// file: hdl/aux_function_command_regs.sv
// Auxiliary function command registers of the servo drive, Avalon-MM slave
//
// What this block does
// - Enable command 1 with the enable condition met enables the drive, 0 disables it.
// - The enable command is kept in non-volatile storage and restored after power-on.
// - Writing 1 to the bandwidth trigger starts a speed bandwidth test.
// - When the bandwidth test ends the block leaves it and starts the result upload to the host.
// - Writing 1 to the inertia trigger starts load inertia identification.
// - After successful identification the inertia ratio is stored without further command.
// - Writing 1 to the analog correction register learns channel one zero drift into its offset.
// - Writing 2 to the analog correction register learns channel two zero drift into its offset.
// - The three trigger registers return to 0 when their operation completes.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/10ps
module aux_function_command_regs
    import aux_cmd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Avalon-MM slave
    input wire avmm_req_t avmm_req_in,
    output avmm_rsp_t avmm_rsp_out,
    // Drive enable
    input wire logic enable_cond_in,
    output logic drive_enable_out,
    // Non-volatile store of the enable command
    input wire logic nv_enable_in,
    output logic nv_store_out,
    output logic nv_enable_out,
    // Bandwidth test engine
    output logic bw_start_out,
    input wire logic bw_done_in,
    output logic upload_start_out,
    // Inertia identification engine
    output logic inertia_start_out,
    input wire logic inertia_done_in,
    input wire logic inertia_ok_in,
    input wire logic [REG_W-1:0] inertia_ratio_in,
    output logic inertia_store_out,
    // Analog inputs for zero-drift learning
    input wire logic sample_valid_in,
    input wire logic [REG_W-1:0] analog_input_one_in,
    input wire logic [REG_W-1:0] analog_input_two_in,
    output logic [REG_W-1:0] analog_one_offset_param_out,
    output logic [REG_W-1:0] analog_two_offset_param_out
);
    logic ack_reg;
    logic wr_take;
    logic rd_take;
    logic [IDX_W-1:0] idx;
    logic [REG_W-1:0] wval;
    logic restore_pend_reg;
    logic [REG_W-1:0] internal_enable_cmd_reg;
    logic [REG_W-1:0] bandwidth_test_trigger_reg;
    logic [REG_W-1:0] inertia_ident_trigger_reg;
    logic [REG_W-1:0] analog_zero_correct_reg;
    logic [REG_W-1:0] inertia_ratio_reg;
    logic inertia_ok_reg;
    logic [DATA_W-1:0] readdata_reg;
    logic zd_start;
    logic zd_busy;
    logic zd_done;
    logic zd_done_two;
    logic [REG_W-1:0] zd_offset;

    // Word index from a byte address
    function automatic logic [IDX_W-1:0] word_index(input logic [ADDR_W-1:0] addr);
        return addr[ADDR_W-1:2];
    endfunction

    // A trigger accepts 1 (or 2 for analog) only while idle
    function automatic logic trig_ok(input logic [REG_W-1:0] cur, input logic [REG_W-1:0] val,
                                     input logic allow_two);
        return (cur == VAL_ZERO) && (val == VAL_ONE || (allow_two && val == VAL_TWO));
    endfunction

    // One wait cycle per access keeps the read mux off the bus path
    assign idx = word_index(avmm_req_in.address);
    assign wval = avmm_req_in.writedata[REG_W-1:0];
    assign wr_take = avmm_req_in.write && ack_reg;
    assign rd_take = avmm_req_in.read && !ack_reg;
    assign avmm_rsp_out = '{readdata: readdata_reg,
                            waitrequest: (avmm_req_in.read || avmm_req_in.write) && !ack_reg};

    // Answer flag, high for the single cycle that ends a request
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avmm_req_in.read || avmm_req_in.write) && !ack_reg;
        end
    end

    // Read mux, loaded one edge before the answer; unmapped reads give zero
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            readdata_reg <= '0;
        end else if (rd_take) begin
            readdata_reg <= '0;
            unique case (idx)
                IDX_ENABLE_CMD: readdata_reg[REG_W-1:0] <= internal_enable_cmd_reg;
                IDX_BW_TRIGGER: readdata_reg[REG_W-1:0] <= bandwidth_test_trigger_reg;
                IDX_INERTIA_TRIGGER: readdata_reg[REG_W-1:0] <= inertia_ident_trigger_reg;
                IDX_ZERO_CORRECT: readdata_reg[REG_W-1:0] <= analog_zero_correct_reg;
                IDX_INERTIA_RATIO: readdata_reg[REG_W-1:0] <= inertia_ratio_reg;
                IDX_OFFSET_ONE: readdata_reg[REG_W-1:0] <= analog_one_offset_param_out;
                IDX_OFFSET_TWO: readdata_reg[REG_W-1:0] <= analog_two_offset_param_out;
                IDX_STATUS: begin
                    readdata_reg[ST_DRIVE_EN] <= drive_enable_out;
                    readdata_reg[ST_BW_BUSY] <= (bandwidth_test_trigger_reg != VAL_ZERO);
                    readdata_reg[ST_INERTIA_BUSY] <= (inertia_ident_trigger_reg != VAL_ZERO);
                    readdata_reg[ST_ZERO_BUSY] <= zd_busy;
                    readdata_reg[ST_INERTIA_OK] <= inertia_ok_reg;
                end
                default: readdata_reg <= '0;
            endcase
        end
    end

    // Enable command: restored from storage once after reset, then written by software
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            restore_pend_reg <= 1'b1;
            internal_enable_cmd_reg <= VAL_ZERO;
            nv_store_out <= 1'b0;
            nv_enable_out <= 1'b0;
        end else begin
            restore_pend_reg <= 1'b0;
            nv_store_out <= 1'b0;
            if (wr_take && idx == IDX_ENABLE_CMD && (wval == VAL_ZERO || wval == VAL_ONE)) begin
                internal_enable_cmd_reg <= wval;
                nv_store_out <= 1'b1;
                nv_enable_out <= wval[0];
            end else if (restore_pend_reg) begin
                internal_enable_cmd_reg <= {15'h0000, nv_enable_in};
            end
        end
    end

    // Drive enable, registered; condition loss disables on the next edge
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            drive_enable_out <= 1'b0;
        end else begin
            drive_enable_out <= (internal_enable_cmd_reg == VAL_ONE) && enable_cond_in;
        end
    end

    // Bandwidth test trigger; busy writes are ignored so done never races a set
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            bandwidth_test_trigger_reg <= VAL_ZERO;
            bw_start_out <= 1'b0;
            upload_start_out <= 1'b0;
        end else begin
            bw_start_out <= 1'b0;
            upload_start_out <= 1'b0;
            if (bandwidth_test_trigger_reg != VAL_ZERO && bw_done_in) begin
                bandwidth_test_trigger_reg <= VAL_ZERO;
                upload_start_out <= 1'b1;
            end else if (wr_take && idx == IDX_BW_TRIGGER
                         && trig_ok(bandwidth_test_trigger_reg, wval, 1'b0)) begin
                bandwidth_test_trigger_reg <= wval;
                bw_start_out <= 1'b1;
            end
        end
    end

    // Inertia identification trigger and result capture
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            inertia_ident_trigger_reg <= VAL_ZERO;
            inertia_start_out <= 1'b0;
            inertia_store_out <= 1'b0;
            inertia_ratio_reg <= VAL_ZERO;
            inertia_ok_reg <= 1'b0;
        end else begin
            inertia_start_out <= 1'b0;
            inertia_store_out <= 1'b0;
            if (inertia_ident_trigger_reg != VAL_ZERO && inertia_done_in) begin
                inertia_ident_trigger_reg <= VAL_ZERO;
                inertia_ok_reg <= inertia_ok_in;
                if (inertia_ok_in) begin
                    inertia_ratio_reg <= inertia_ratio_in;
                    inertia_store_out <= 1'b1;
                end
            end else if (wr_take && idx == IDX_INERTIA_TRIGGER
                         && trig_ok(inertia_ident_trigger_reg, wval, 1'b0)) begin
                inertia_ident_trigger_reg <= wval;
                inertia_start_out <= 1'b1;
            end
        end
    end

    // Analog self-correction request; the source is assumed at 0V when asked
    assign zd_start = wr_take && idx == IDX_ZERO_CORRECT
                      && trig_ok(analog_zero_correct_reg, wval, 1'b1);

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            analog_zero_correct_reg <= VAL_ZERO;
        end else if (zd_done) begin
            analog_zero_correct_reg <= VAL_ZERO;
        end else if (zd_start) begin
            analog_zero_correct_reg <= wval;
        end
    end

    // Learned offsets land in the channel's own parameter
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            analog_one_offset_param_out <= VAL_ZERO;
            analog_two_offset_param_out <= VAL_ZERO;
        end else if (zd_done) begin
            if (zd_done_two) begin
                analog_two_offset_param_out <= zd_offset;
            end else begin
                analog_one_offset_param_out <= zd_offset;
            end
        end
    end

    zero_drift_learner u_learner (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .start_in(zd_start),
        .chan_two_in(wval == VAL_TWO),
        .sample_valid_in(sample_valid_in),
        .sample_one_in(analog_input_one_in),
        .sample_two_in(analog_input_two_in),
        .busy_out(zd_busy),
        .done_out(zd_done),
        .done_two_out(zd_done_two),
        .offset_out(zd_offset)
    );

    // Checks
    a_drive_enable_follow: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (internal_enable_cmd_reg == VAL_ONE && enable_cond_in) |=> drive_enable_out)
        else $error("drive not enabled after command and condition");

    a_drive_disable_cmd: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (internal_enable_cmd_reg == VAL_ZERO) |=> !drive_enable_out)
        else $error("drive enabled with command off");

    a_enable_restore: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (restore_pend_reg && !wr_take) |=> internal_enable_cmd_reg == {15'h0000, $past(nv_enable_in)})
        else $error("enable command not restored from storage");

    a_bw_start_pulse: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (wr_take && idx == IDX_BW_TRIGGER && wval == VAL_ONE && bandwidth_test_trigger_reg == VAL_ZERO
         && !bw_done_in) |=> bw_start_out ##1 !bw_start_out)
        else $error("bandwidth test not started once");

    a_bw_done_upload: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (bandwidth_test_trigger_reg != VAL_ZERO && bw_done_in)
        |=> upload_start_out && bandwidth_test_trigger_reg == VAL_ZERO)
        else $error("bandwidth test end not handled");

    a_inertia_start_pulse: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        inertia_start_out |-> $past(inertia_ident_trigger_reg) == VAL_ZERO
        && inertia_ident_trigger_reg == VAL_ONE)
        else $error("inertia start without idle to one");

    a_inertia_stored: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (inertia_ident_trigger_reg != VAL_ZERO && inertia_done_in && inertia_ok_in)
        |=> inertia_store_out && inertia_ratio_reg == $past(inertia_ratio_in)
        && inertia_ident_trigger_reg == VAL_ZERO)
        else $error("inertia result not stored");

    a_zero_one_start: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (zd_start && wval == VAL_ONE) |=> zd_busy && analog_zero_correct_reg == VAL_ONE)
        else $error("channel one correction not started");

    a_zero_two_result: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (zd_done && zd_done_two) |=> analog_two_offset_param_out == $past(zd_offset)
        && analog_zero_correct_reg == VAL_ZERO)
        else $error("channel two offset not stored");

    a_zero_write_nop: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (wr_take && wval == VAL_ZERO && idx == IDX_INERTIA_TRIGGER) |=> !inertia_start_out)
        else $error("write of zero started an operation");

    a_bad_value_kept: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (wr_take && idx == IDX_ENABLE_CMD && wval > VAL_ONE) |=> $stable(internal_enable_cmd_reg))
        else $error("undefined enable value stored");

    a_wait_bounded: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (avmm_req_in.read || avmm_req_in.write) |-> ##[0:1] !avmm_rsp_out.waitrequest)
        else $error("waitrequest held too long");
endmodule

// file: hdl/aux_cmd_pkg.sv
// Shared constants and carrier types for the auxiliary command register bank
package aux_cmd_pkg;
    // Bus widths
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int IDX_W = 14;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_ENABLE_CMD = 14'h3f03;
    localparam logic [IDX_W-1:0] IDX_BW_TRIGGER = 14'h3f04;
    localparam logic [IDX_W-1:0] IDX_INERTIA_TRIGGER = 14'h3f05;
    localparam logic [IDX_W-1:0] IDX_ZERO_CORRECT = 14'h3f06;
    localparam logic [IDX_W-1:0] IDX_INERTIA_RATIO = 14'h3f20;
    localparam logic [IDX_W-1:0] IDX_OFFSET_ONE = 14'h3f21;
    localparam logic [IDX_W-1:0] IDX_OFFSET_TWO = 14'h3f22;
    localparam logic [IDX_W-1:0] IDX_STATUS = 14'h3f23;

    // Register values
    localparam logic [REG_W-1:0] VAL_ZERO = 16'h0000;
    localparam logic [REG_W-1:0] VAL_ONE = 16'h0001;
    localparam logic [REG_W-1:0] VAL_TWO = 16'h0002;

    // Status register bit positions
    localparam int ST_DRIVE_EN = 0;
    localparam int ST_BW_BUSY = 1;
    localparam int ST_INERTIA_BUSY = 2;
    localparam int ST_ZERO_BUSY = 3;
    localparam int ST_INERTIA_OK = 4;

    // Zero-drift averaging: sample count is two to the shift
    localparam int ZD_SHIFT = 4;
    localparam logic [ZD_SHIFT-1:0] ZD_LAST = 4'hf;
    localparam int ZD_SUM_W = REG_W + ZD_SHIFT;

    // Avalon-MM request and answer
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
    } avmm_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] readdata;
        logic waitrequest;
    } avmm_rsp_t;

    // Zero-drift learner states
    typedef enum logic {ZD_IDLE, ZD_ACCUM} zd_state_t;
endpackage

// file: hdl/zero_drift_learner.sv
// Zero-drift learner: averages samples of one analog channel into an offset
`timescale 1ns/10ps
module zero_drift_learner
    import aux_cmd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Command
    input wire logic start_in,
    input wire logic chan_two_in,
    // Samples
    input wire logic sample_valid_in,
    input wire logic [REG_W-1:0] sample_one_in,
    input wire logic [REG_W-1:0] sample_two_in,
    // Result
    output logic busy_out,
    output logic done_out,
    output logic done_two_out,
    output logic [REG_W-1:0] offset_out
);
    zd_state_t state_reg;
    logic chan_two_reg;
    logic [ZD_SHIFT-1:0] count_reg;
    logic signed [ZD_SUM_W-1:0] sum_reg;
    logic signed [ZD_SUM_W-1:0] sum_next;
    logic [REG_W-1:0] sample;

    // Pick the channel latched at start, widen with its sign
    always_comb begin
        sample = chan_two_reg ? sample_two_in : sample_one_in;
        sum_next = sum_reg + ZD_SUM_W'(signed'(sample));
    end

    // Sequence: start clears the sum, each valid sample adds
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= ZD_IDLE;
            chan_two_reg <= 1'b0;
            count_reg <= '0;
            sum_reg <= '0;
        end else begin
            unique case (state_reg)
                ZD_IDLE: begin
                    if (start_in) begin
                        state_reg <= ZD_ACCUM;
                        chan_two_reg <= chan_two_in;
                        count_reg <= '0;
                        sum_reg <= '0;
                    end
                end
                ZD_ACCUM: begin
                    if (sample_valid_in) begin
                        sum_reg <= sum_next;
                        count_reg <= count_reg + 1'b1;
                        if (count_reg == ZD_LAST) begin
                            state_reg <= ZD_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Result registers; the mean is the drift to subtract later
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            done_out <= 1'b0;
            done_two_out <= 1'b0;
            offset_out <= '0;
        end else begin
            done_out <= 1'b0;
            if (state_reg == ZD_ACCUM && sample_valid_in && count_reg == ZD_LAST) begin
                done_out <= 1'b1;
                done_two_out <= chan_two_reg;
                offset_out <= sum_next[ZD_SUM_W-1:ZD_SHIFT];
            end
        end
    end

    assign busy_out = (state_reg == ZD_ACCUM);
endmodule

// file: test/engine_model.sv
// Model of the test engines and analog inputs behind the command bank
`timescale 1ns/10ps
module engine_model
    import aux_cmd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Scenario settings
    input wire logic [7:0] delay_in,
    input wire logic ok_in,
    input wire logic [REG_W-1:0] ratio_in,
    input wire logic [REG_W-1:0] base_one_in,
    input wire logic [REG_W-1:0] base_two_in,
    input wire logic [REG_W-1:0] delta_in,
    // Engines
    input wire logic bw_start_in,
    input wire logic inertia_start_in,
    output logic bw_done_out,
    output logic inertia_done_out,
    output logic inertia_ok_out,
    output logic [REG_W-1:0] inertia_ratio_out,
    // Analog samples
    output logic sample_valid_out,
    output logic [REG_W-1:0] sample_one_out,
    output logic [REG_W-1:0] sample_two_out
);
    logic [7:0] bw_cnt_reg;
    logic [7:0] in_cnt_reg;
    logic [1:0] ph_reg;
    logic sign_reg;

    // Engine run time; outcome lines carry junk outside the done cycle
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            bw_cnt_reg <= 8'h00;
            in_cnt_reg <= 8'h00;
            bw_done_out <= 1'b0;
            inertia_done_out <= 1'b0;
            inertia_ok_out <= 1'b0;
            inertia_ratio_out <= 16'h0000;
        end else begin
            bw_cnt_reg <= bw_start_in ? delay_in : bw_cnt_reg - {7'h00, bw_cnt_reg != 8'h00};
            in_cnt_reg <= inertia_start_in ? delay_in : in_cnt_reg - {7'h00, in_cnt_reg != 8'h00};
            bw_done_out <= (bw_cnt_reg == 8'h01);
            inertia_done_out <= (in_cnt_reg == 8'h01);
            inertia_ok_out <= (in_cnt_reg == 8'h01) ? ok_in : ~inertia_ok_out;
            inertia_ratio_out <= (in_cnt_reg == 8'h01) ? ratio_in : ~inertia_ratio_out;
        end
    end

    // Source commanded to 0V; jitter alternates so it cancels over an even run
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ph_reg <= 2'h0;
            sign_reg <= 1'b0;
            sample_valid_out <= 1'b0;
            sample_one_out <= 16'h0000;
            sample_two_out <= 16'h0000;
        end else begin
            ph_reg <= (ph_reg == 2'h2) ? 2'h0 : ph_reg + 2'h1;
            sample_valid_out <= (ph_reg == 2'h2);
            sign_reg <= sign_reg ^ (ph_reg == 2'h2);
            sample_one_out <= (ph_reg != 2'h2) ? ~sample_one_out
                              : sign_reg ? base_one_in + delta_in : base_one_in - delta_in;
            sample_two_out <= (ph_reg != 2'h2) ? ~sample_two_out
                              : sign_reg ? base_two_in + delta_in : base_two_in - delta_in;
        end
    end
endmodule

// file: test/tb.sv
// Self-checking bench for the auxiliary command register bank
`timescale 1ns/10ps
module tb
    import aux_cmd_pkg::*;
();
    logic ref_clk_in, rst_in, enable_cond, nv_en, drive_en, nv_store, nv_val, bw_start, bw_done, upload;
    logic in_start, in_done, in_ok, in_store, s_valid, ok_set;
    logic [REG_W-1:0] in_ratio, s_one, s_two, off_one, off_two, ratio_set, base_one, base_two, delta, exp_ratio;
    logic [REG_W-1:0] bad [3] = '{16'h0000, 16'h0003, 16'h8001};
    logic [7:0] delay;
    logic [31:0] seed, rd, r;
    avmm_req_t req;
    avmm_rsp_t rsp;
    int fails, n_compared, n_bw, n_up, n_in, n_st, n_nv, exp_st;

    aux_function_command_regs i_aux_function_command_regs (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .avmm_req_in(req), .avmm_rsp_out(rsp), .enable_cond_in(enable_cond), .drive_enable_out(drive_en),
        .nv_enable_in(nv_en), .nv_store_out(nv_store), .nv_enable_out(nv_val), .bw_start_out(bw_start),
        .bw_done_in(bw_done), .upload_start_out(upload), .inertia_start_out(in_start),
        .inertia_done_in(in_done), .inertia_ok_in(in_ok), .inertia_ratio_in(in_ratio),
        .inertia_store_out(in_store), .sample_valid_in(s_valid), .analog_input_one_in(s_one),
        .analog_input_two_in(s_two), .analog_one_offset_param_out(off_one), .analog_two_offset_param_out(off_two));

    engine_model i_engine_model (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .delay_in(delay), .ok_in(ok_set),
        .ratio_in(ratio_set), .base_one_in(base_one), .base_two_in(base_two), .delta_in(delta),
        .bw_start_in(bw_start), .inertia_start_in(in_start), .bw_done_out(bw_done), .inertia_done_out(in_done),
        .inertia_ok_out(in_ok), .inertia_ratio_out(in_ratio), .sample_valid_out(s_valid),
        .sample_one_out(s_one), .sample_two_out(s_two));

    // 125 MHz clock
    initial begin
        ref_clk_in = 1'b0;
        forever #4 ref_clk_in = ~ref_clk_in;
    end

    // Pulses stand one cycle, so they are counted at the edge that ends them
    always @(posedge ref_clk_in) begin
        n_bw += (bw_start === 1'b1);
        n_up += (upload === 1'b1);
        n_in += (in_start === 1'b1);
        n_st += (in_store === 1'b1);
        n_nv += (nv_store === 1'b1);
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Signed mean of sixteen alternating samples, shifted arithmetically
    function automatic logic [15:0] exp_offset(input logic [15:0] b, input logic [15:0] d);
        logic [19:0] sum;
        logic [15:0] s;
        sum = 20'h0_0000;
        for (int k = 0; k < 16; k++) begin
            s = (k % 2 == 1) ? b + d : b - d;
            sum = sum + {{4{s[15]}}, s};
        end
        return sum[19:4];
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus cycle; request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [15:0] d);
        int n;
        n = 0;
        req <= '{read: !wr, write: wr, address: {idx, 2'h0}, writedata: {16'h0000, d}};
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (rsp.waitrequest !== 1'b0 && n < 40);
        rd = rsp.readdata;
        req <= '0;
        @(posedge ref_clk_in);
        if (n >= 40) chk("waitrequest", 32'h0000_0000, 32'h0000_0001);
    endtask

    task automatic rd_chk(input string what, input logic [IDX_W-1:0] idx, input logic [15:0] exp);
        bus(1'b0, idx, 16'h0000);
        chk(what, {16'h0000, exp}, rd);
    endtask

    // Poll a trigger until it clears by itself
    task automatic wait_idle(input logic [IDX_W-1:0] idx);
        int n;
        n = 0;
        do begin
            bus(1'b0, idx, 16'h0000);
            n++;
        end while (rd !== 32'h0000_0000 && n < 100);
        chk("trigger cleared", 32'h0000_0000, rd);
    endtask

    task automatic do_reset(input logic nv);
        rst_in <= 1'b1;
        nv_en <= nv;
        repeat (6) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
    endtask

    task automatic wrap_up();
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run of a few hundred cycles
    initial begin
        repeat (30000) @(posedge ref_clk_in);
        fails++;
        wrap_up();
    end

    initial begin
        {seed, fails, n_compared, n_bw, n_up, n_in, n_st, n_nv, exp_st} = {32'd85, 256'h0};
        {rst_in, enable_cond, nv_en, ok_set, req, delay} = {4'hf, 50'h0, 8'h05};
        {ratio_set, base_one, base_two, delta, exp_ratio} = 80'h0;
        do_reset(1'b1);
        rd_chk("enable restored", IDX_ENABLE_CMD, VAL_ONE);
        chk("drive enabled", 32'h0000_0001, {31'h0, drive_en});
        bus(1'b1, IDX_ENABLE_CMD, 16'h0005);
        rd_chk("enable kept", IDX_ENABLE_CMD, VAL_ONE);
        chk("no store", 32'h0000_0000, n_nv);
        enable_cond <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        chk("condition lost", 32'h0000_0000, {31'h0, drive_en});
        bus(1'b1, IDX_ENABLE_CMD, VAL_ZERO);
        enable_cond <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        chk("disabled", 32'h0000_0000, {31'h0, drive_en});
        chk("stored value", 32'h0000_0000, {31'h0, nv_val});
        chk("store pulse", 32'h0000_0001, n_nv);
        do_reset(nv_val);
        rd_chk("enable after power-on", IDX_ENABLE_CMD, VAL_ZERO);
        chk("stays off", 32'h0000_0000, {31'h0, drive_en});
        enable_cond <= 1'b0;
        bus(1'b1, IDX_ENABLE_CMD, VAL_ONE);
        chk("enable without condition", 32'h0000_0000, {31'h0, drive_en});
        enable_cond <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        chk("enable with condition", 32'h0000_0001, {31'h0, drive_en});
        bus(1'b1, 14'h0000, VAL_ONE);
        rd_chk("unmapped", 14'h0000, VAL_ZERO);
        bus(1'b1, IDX_STATUS, 16'h00ff);
        rd_chk("status", IDX_STATUS, 16'h0001);
        // Zero and undefined values must start nothing
        foreach (bad[i]) begin
            bus(1'b1, IDX_BW_TRIGGER, bad[i]);
            bus(1'b1, IDX_INERTIA_TRIGGER, bad[i]);
            bus(1'b1, IDX_ZERO_CORRECT, bad[i]);
            rd_chk("bw idle", IDX_BW_TRIGGER, VAL_ZERO);
            rd_chk("inertia idle", IDX_INERTIA_TRIGGER, VAL_ZERO);
            rd_chk("zero idle", IDX_ZERO_CORRECT, VAL_ZERO);
        end
        chk("no start", 32'h0000_0000, n_bw + n_in);
        chk("offsets untouched", 32'h0000_0000, {off_one, off_two});
        // Random rounds; the second identification fails
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            delay <= {3'h0, r[4:0]} + 8'h01;
            ok_set <= (i != 1);
            ratio_set <= r[31:16];
            base_one <= {{6{r[9]}}, r[9:0]};
            base_two <= {{6{r[20]}}, r[20:11]};
            delta <= {4'h0, r[31:20]};
            exp_ratio = (i != 1) ? r[31:16] : exp_ratio;
            exp_st += (i != 1);
            bus(1'b1, IDX_BW_TRIGGER, VAL_ONE);
            bus(1'b1, IDX_INERTIA_TRIGGER, VAL_ONE);
            bus(1'b1, IDX_ZERO_CORRECT, (i % 2 == 1) ? VAL_TWO : VAL_ONE);
            wait_idle(IDX_BW_TRIGGER);
            wait_idle(IDX_INERTIA_TRIGGER);
            wait_idle(IDX_ZERO_CORRECT);
            chk("bw starts", i + 1, n_bw);
            chk("uploads", i + 1, n_up);
            chk("inertia starts", i + 1, n_in);
            chk("inertia stores", exp_st, n_st);
            rd_chk("inertia ratio", IDX_INERTIA_RATIO, exp_ratio);
            if (i % 2 == 1) chk("offset two", {16'h0000, exp_offset(base_two, delta)}, {16'h0000, off_two});
            else chk("offset one", {16'h0000, exp_offset(base_one, delta)}, {16'h0000, off_one});
        end
        wrap_up();
    end
endmodule
